// file: src/ebr_top.sv
// External bus controller with per-region timing over an APB register port.
// Assumes synchronous pins, a 250 MHz clock and an outside window decoder.
//
// Overview of operation
// (RULE_01) Memory wait states equal fifteen minus the four-bit wait field.
// (RULE_02) Command delay bit 0 delays command one half period after strobe.
// (RULE_03) Tristate bit 0 adds one tristate wait state; 1 adds none.
// (RULE_04) Two-bit type field selects 8/16-bit, multiplexed or demultiplexed bus.
// (RULE_05) Region zero loads its bus type from configuration pins at reset.
// (RULE_06) Strobe lengthening bit 1 gives a lengthened address-latch strobe.
// (RULE_07) Bus cycles run only for active regions inside their window.
// (RULE_08) Ready enable 0 ends cycles by wait count; 1 by ready input.
// (RULE_09) Ready polarity bit 0 means low active; 1 means high active.
// (RULE_10) Read gating bit 1 limits chip select to the read command.
// (RULE_11) Write gating bit 1 limits chip select to write command strobes.
// (RULE_12) Latched write-config bit 0 turns write and byte pins into strobes.
// (RULE_13) Segment line field sets four, none, eight or two segment lines.
// (RULE_14) Reset latch captures configuration pins every reset; read-only.
// (RULE_15) Clock select bits reload only during a long hardware reset.
// (RULE_16) Each access uses the single matching region configuration.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module ebr_top
  import ebr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset straps.
  input wire logic [7:0] configurationPort,
  input wire logic longReset,
  // Access request from the core.
  input wire logic accReq,
  input wire logic accWrite,
  input wire logic [1:0] accByteEn,
  input wire logic [23:0] accAddr,
  input wire logic [15:0] accWdata,
  input wire logic [NUM_REGIONS-1:0] regionHit,
  output logic accDone,
  output logic accRefused,
  output logic [15:0] accRdata,
  // External bus pins.
  output logic latchStrobe,
  output logic readCmdN,
  output logic writeCmdN,
  output logic upperByteEnableN,
  output logic [NUM_REGIONS-1:0] chipSelectN,
  output logic [23:0] addrOut,
  output logic [15:0] adOut,
  output logic adOe,
  input wire logic [15:0] adIn,
  input wire logic readyPin,
  output logic [1:0] busTypeOut,
  output logic [3:0] segmentLines,
  output logic [1:0] selectLineCount,
  output logic [2:0] clockMultiplierSelect
);
  logic [15:0] regionCfg_reg [NUM_REGIONS];
  logic [4:0] resetLatch_reg;
  logic [2:0] clock_multiplier_select_reg;
  logic captured_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  ebr_state_t state_reg;
  ebr_state_t state_next;
  logic [15:0] cycCfg_reg;
  logic [2:0] cycRegion_reg;
  logic cycWrite_reg;
  logic [1:0] cycByteEn_reg;
  logic [23:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic done_reg;
  logic refused_reg;
  logic [16*NUM_REGIONS-1:0] cfgFlat;
  logic [2:0] selIndex;
  logic [15:0] selCfg;
  logic cntLoad;
  logic [5:0] cntValue;
  logic cntDone;
  logic readyActive;
  logic cmdOn;
  logic csOn;
  logic busy;
  logic byteStrobeMode;
  logic setupPhase;
  logic accessPhase;
  logic [2:0] regIdx;
  logic regHit;
  logic latchHit;

  // Command phase length including programmed wait states.
  function automatic logic [5:0] cmd_clks(input logic [15:0] cfg);
    logic [5:0] waits;
    waits = 6'(WAIT_FIELD_MAX - cfg[F_WAIT_LSB +: 4]);
    return CMD_BASE_CLKS + 6'(waits * WAIT_STATE_CLKS);
  endfunction

  // Number of segment address lines for a segment field encoding.
  function automatic logic [3:0] seg_lines(input logic [1:0] code);
    case (code)
      2'h0: return 4'h4;
      2'h1: return 4'h0;
      2'h2: return 4'h8;
      default: return 4'h2;
    endcase
  endfunction

  // APB decode.
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign regIdx = 3'((paddr - ADDR_REGION_BASE) >> 2);
  assign regHit = (paddr >= ADDR_REGION_BASE) && (paddr[1:0] == 2'h0)
    && (paddr < ADDR_REGION_BASE + 16'(NUM_REGIONS) * ADDR_REGION_STEP);
  assign latchHit = (paddr == ADDR_RESET_LATCH);
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // Read data and error are prepared in the setup cycle so that the
  // access phase always completes with no wait state.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else if (setupPhase)
    begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= !(regHit || latchHit) || (latchHit && pwrite); // [RULE_14]
      if (!pwrite && regHit)
        prdata_reg <= {16'h0000, regionCfg_reg[regIdx]};
      else if (!pwrite && latchHit)
        prdata_reg <= {24'h000000, clock_multiplier_select_reg, resetLatch_reg};
    end
  end

  // Region configuration registers; region zero takes its type from pins.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NUM_REGIONS; i++)
        regionCfg_reg[i] <= REGION_RESET;
    end
    else if (!captured_reg)
      regionCfg_reg[0][F_TYPE_LSB +: 2] <=
        configurationPort[CFG_TYPE_LSB +: 2]; // [RULE_05]
    else if (accessPhase && pwrite && regHit)
      regionCfg_reg[regIdx] <= pwdata[15:0] & REGION_WRITE_MASK;
  end

  // The strap pins cannot feed the asynchronous reset, so they are caught
  // at the first edge after its release.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      resetLatch_reg <= LATCH_RESET[L_CLK_LSB-1:0];
      captured_reg <= 1'b0;
    end
    else if (!captured_reg)
    begin
      captured_reg <= 1'b1;
      resetLatch_reg <= configurationPort[L_CLK_LSB-1:0]; // [RULE_14]
    end
  end

  // Clock select must survive a short reset, so it has no reset of its
  // own; it stays unknown until the first long reset has been seen.
  always_ff @(posedge clk)
  begin
    if (!captured_reg && longReset)
      clock_multiplier_select_reg <= configurationPort[7:L_CLK_LSB]; // [RULE_15]
  end

  assign byteStrobeMode = !resetLatch_reg[L_WRC]; // [RULE_12]
  assign segmentLines = seg_lines(resetLatch_reg[L_SEG_LSB +: 2]); // [RULE_13]
  assign selectLineCount = resetLatch_reg[L_SELECT_LINE_COUNT_LSB +: 2];
  assign clockMultiplierSelect = clock_multiplier_select_reg;

  always_comb
  begin
    for (int i = 0; i < NUM_REGIONS; i++)
      cfgFlat[16*i +: 16] = regionCfg_reg[i];
  end

  ebr_region_select u_select (
    .regionHit(regionHit),
    .regionCfgFlat(cfgFlat),
    .regionIndex(selIndex),
    .regionCfg(selCfg)
  );

  ebr_wait_counter u_counter (
    .clk(clk),
    .resetn(resetn),
    .load(cntLoad),
    .loadValue(cntValue),
    .done(cntDone)
  );

  assign readyActive = cycCfg_reg[F_RDY_POL] ? readyPin : !readyPin; // [RULE_09]

  // Cycle sequencer and the counter loads for each phase.
  always_comb
  begin
    state_next = state_reg;
    cntLoad = 1'b0;
    cntValue = 6'h00;
    case (state_reg)
      ST_IDLE:
      begin
        if (accReq && selCfg[F_ACTIVE]) // [RULE_07]
        begin
          state_next = ST_LATCH;
          cntLoad = 1'b1;
          cntValue = selCfg[F_LATCH_LEN] ? HALF_PERIOD_CLKS : 6'h00; // [RULE_06]
        end
      end
      ST_LATCH:
      begin
        if (cntDone)
        begin
          cntLoad = 1'b1;
          if (!cycCfg_reg[F_CMD_DELAY]) // [RULE_02]
          begin
            state_next = ST_DELAY;
            cntValue = HALF_PERIOD_CLKS - 6'h01;
          end
          else
          begin
            state_next = ST_CMD;
            cntValue = cmd_clks(cycCfg_reg) - 6'h01; // [RULE_01]
          end
        end
      end
      ST_DELAY:
      begin
        if (cntDone)
        begin
          state_next = ST_CMD;
          cntLoad = 1'b1;
          cntValue = cmd_clks(cycCfg_reg) - 6'h01; // [RULE_01]
        end
      end
      ST_CMD:
      begin
        if (cntDone)
        begin
          if (cycCfg_reg[F_RDY_EN]) // [RULE_08]
            state_next = ST_READY;
          else if (!cycCfg_reg[F_TRISTATE]) // [RULE_03]
          begin
            state_next = ST_TRIS;
            cntLoad = 1'b1;
            cntValue = WAIT_STATE_CLKS - 6'h01;
          end
          else
            state_next = ST_IDLE;
        end
      end
      ST_READY:
      begin
        if (readyActive) // [RULE_08]
        begin
          if (!cycCfg_reg[F_TRISTATE]) // [RULE_03]
          begin
            state_next = ST_TRIS;
            cntLoad = 1'b1;
            cntValue = WAIT_STATE_CLKS - 6'h01;
          end
          else
            state_next = ST_IDLE;
        end
      end
      ST_TRIS:
      begin
        if (cntDone)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Per-cycle copy of the governing configuration and the request.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cycCfg_reg <= REGION_RESET;
      cycRegion_reg <= 3'h0;
      cycWrite_reg <= 1'b0;
      cycByteEn_reg <= 2'h0;
      addr_reg <= 24'h000000;
      wdata_reg <= 16'h0000;
    end
    else if (state_reg == ST_IDLE && accReq)
    begin
      cycCfg_reg <= selCfg; // [RULE_16]
      cycRegion_reg <= selIndex;
      cycWrite_reg <= accWrite;
      cycByteEn_reg <= accByteEn;
      addr_reg <= accAddr;
      wdata_reg <= accWdata;
    end
  end

  // Completion, refusal and read data capture.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      done_reg <= busy && state_next == ST_IDLE;
      refused_reg <= state_reg == ST_IDLE && accReq
        && !selCfg[F_ACTIVE]; // [RULE_07]
      if (!cycWrite_reg && cmdOn && state_next != state_reg
          && state_next != ST_CMD)
        rdata_reg <= adIn;
    end
  end

  assign accDone = done_reg;
  assign accRefused = refused_reg;
  assign accRdata = rdata_reg;

  // Pin decode from the sequencer state.
  assign busy = state_reg != ST_IDLE;
  assign cmdOn = state_reg == ST_CMD || state_reg == ST_READY;
  assign latchStrobe = state_reg == ST_LATCH;
  assign readCmdN = !(cmdOn && !cycWrite_reg);

  always_comb
  begin
    csOn = busy && state_reg != ST_TRIS;
    if (!cycWrite_reg && cycCfg_reg[F_RD_GATED])
      csOn = cmdOn; // [RULE_10]
    if (cycWrite_reg && cycCfg_reg[F_WR_GATED])
      csOn = cmdOn; // [RULE_11]
    chipSelectN = '1;
    chipSelectN[cycRegion_reg] = !csOn;
  end

  // In byte strobe mode the write pin strobes the low byte and the upper
  // byte pin strobes the high byte; otherwise they keep their usual roles.
  always_comb
  begin
    if (byteStrobeMode) // [RULE_12]
    begin
      writeCmdN = !(cmdOn && cycWrite_reg && cycByteEn_reg[0]);
      upperByteEnableN = !(cmdOn && cycWrite_reg && cycByteEn_reg[1]);
    end
    else
    begin
      writeCmdN = !(cmdOn && cycWrite_reg);
      upperByteEnableN = !(busy && cycByteEn_reg[1]
        && cycCfg_reg[F_TYPE_LSB + 1]);
    end
  end

  // A multiplexed bus carries the address on the data lines while the
  // latch strobe is high; on an 8-bit bus the write data only uses the low byte lane.
  assign busTypeOut = cycCfg_reg[F_TYPE_LSB +: 2]; // [RULE_04]
  assign addrOut = addr_reg;
  always_comb
  begin
    adOe = 1'b0;
    adOut = 16'h0000;
    if (latchStrobe && (busTypeOut == BT_MUX8 || busTypeOut == BT_MUX16))
    begin
      adOe = 1'b1;
      adOut = addr_reg[15:0]; // [RULE_04]
    end
    else if (cmdOn && cycWrite_reg)
    begin
      adOe = 1'b1;
      adOut = (busTypeOut == BT_DEMUX8 || busTypeOut == BT_MUX8)
        ? {8'h00, wdata_reg[7:0]} : wdata_reg;
    end
  end

  // Helper count of command cycles for checking.
  logic [5:0] cmdCount_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cmdCount_reg <= 6'h00;
    else if (state_reg == ST_CMD)
      cmdCount_reg <= cmdCount_reg + 6'h01;
    else
      cmdCount_reg <= 6'h00;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_wait_length: assert property ( // [RULE_01]
    (state_reg == ST_CMD && cntDone)
    |-> cmdCount_reg + 6'h01 == cmd_clks(cycCfg_reg))
    else $error("Command phase length does not match wait field.");
  a_cmd_delay: assert property ( // [RULE_02]
    (state_reg == ST_LATCH && cntDone)
    |=> (state_reg == ST_DELAY) == !cycCfg_reg[F_CMD_DELAY])
    else $error("Command delay does not follow its control bit.");
  a_tris_only: assert property ( // [RULE_03]
    $rose(state_reg == ST_TRIS) |-> !cycCfg_reg[F_TRISTATE]
      ##1 state_reg == ST_TRIS ##1 state_reg == ST_IDLE)
    else $error("Tristate wait is wrong.");
  a_latch_length: assert property ( // [RULE_06]
    $rose(latchStrobe) |=> latchStrobe == cycCfg_reg[F_LATCH_LEN])
    else $error("Latch strobe length does not follow its control bit.");
  a_inactive_refuse: assert property ( // [RULE_07]
    (state_reg == ST_IDLE && accReq && !selCfg[F_ACTIVE])
    |=> accRefused && state_reg == ST_IDLE)
    else $error("Inactive region access was not refused.");
  a_ready_hold: assert property ( // [RULE_09]
    (state_reg == ST_READY && !readyActive) |=> state_reg == ST_READY)
    else $error("Ready cycle ended without active ready.");
  a_no_ready: assert property ( // [RULE_08]
    !cycCfg_reg[F_RDY_EN] |-> state_reg != ST_READY)
    else $error("Ready wait entered while ready is disabled.");
  a_read_select: assert property ( // [RULE_10]
    (busy && !cycWrite_reg && cycCfg_reg[F_RD_GATED])
    |-> chipSelectN[cycRegion_reg] == readCmdN)
    else $error("Read-gated chip select differs from read command.");
  a_write_select: assert property ( // [RULE_11]
    (busy && cycWrite_reg && cycCfg_reg[F_WR_GATED])
    |-> chipSelectN[cycRegion_reg] == !cmdOn)
    else $error("Write-gated chip select differs from write command.");
  a_latch_readonly: assert property ( // [RULE_14]
    (setupPhase && pwrite && latchHit) |=> pslverr && pready)
    else $error("Write to the reset latch was not rejected.");

  c_ready_cycle: cover property (state_reg == ST_READY ##1 accDone);
  c_tris_cycle: cover property (state_reg == ST_TRIS ##2 accDone);
  c_refused: cover property (accRefused);
  c_byte_write: cover property (byteStrobeMode && !writeCmdN);
endmodule

// file: inc/ebr_pkg.sv
// Constants for the external bus region timing block: register map,
// field positions, reset values, timing counts and the cycle state type.
// Assumes a 250 MHz clock in which one clock period is one half CPU period.
package ebr_pkg;
  localparam int NUM_REGIONS = 5;
  // Register map, byte addresses on the APB.
  localparam logic [15:0] ADDR_REGION_BASE = 16'hF000;
  localparam logic [15:0] ADDR_REGION_STEP = 16'h0004;
  localparam logic [15:0] ADDR_RESET_LATCH = 16'hF108;
  // Fields of bus_region_config.
  localparam int F_WAIT_LSB = 0;
  localparam int F_CMD_DELAY = 4;
  localparam int F_TRISTATE = 5;
  localparam int F_TYPE_LSB = 6;
  localparam int F_LATCH_LEN = 9;
  localparam int F_ACTIVE = 10;
  localparam int F_RDY_EN = 12;
  localparam int F_RDY_POL = 13;
  localparam int F_RD_GATED = 14;
  localparam int F_WR_GATED = 15;
  localparam logic [15:0] REGION_WRITE_MASK = 16'hF6FF;
  localparam logic [15:0] REGION_RESET = 16'h0000;
  // Fields of reset_bus_config_latch.
  localparam int L_WRC = 0;
  localparam int L_SELECT_LINE_COUNT_LSB = 1;
  localparam int L_SEG_LSB = 3;
  localparam int L_CLK_LSB = 5;
  localparam int CFG_TYPE_LSB = 6;
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  // Bus type encodings.
  localparam logic [1:0] BT_DEMUX8 = 2'h0;
  localparam logic [1:0] BT_MUX8 = 2'h1;
  localparam logic [1:0] BT_DEMUX16 = 2'h2;
  localparam logic [1:0] BT_MUX16 = 2'h3;
  // Timing counts in clock cycles.
  localparam logic [3:0] WAIT_FIELD_MAX = 4'hF;
  localparam logic [5:0] HALF_PERIOD_CLKS = 6'h01;
  localparam logic [5:0] WAIT_STATE_CLKS = 6'h02;
  localparam logic [5:0] CMD_BASE_CLKS = 6'h02;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LATCH, ST_DELAY, ST_CMD, ST_READY, ST_TRIS
  } ebr_state_t;
endpackage

// file: src/ebr_wait_counter.sv
// Down counter that times the latch, delay, command and tristate phases of an external bus cycle.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module ebr_wait_counter
  import ebr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Load and status.
  input wire logic load,
  input wire logic [5:0] loadValue,
  output logic done
);
  logic [5:0] count_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      count_reg <= 6'h00;
    else if (load)
      count_reg <= loadValue;
    else if (count_reg != 6'h00)
      count_reg <= count_reg - 6'h01;
  end

  assign done = (count_reg == 6'h00);
endmodule

// file: src/ebr_region_select.sv
// Picks the one region configuration that governs an access.
// Assumes the address window decoder outside gives one hit bit per region.
`timescale 1ns/1ns
module ebr_region_select
  import ebr_pkg::*;
(
  // Window hits and configurations.
  input wire logic [NUM_REGIONS-1:0] regionHit,
  input wire logic [16*NUM_REGIONS-1:0] regionCfgFlat,
  // Selected region.
  output logic [2:0] regionIndex,
  output logic [15:0] regionCfg
);
  // Region zero takes every access that no other window claims.
  always_comb
  begin
    regionIndex = 3'h0;
    for (int i = NUM_REGIONS - 1; i >= 1; i--)
    begin
      if (regionHit[i])
        regionIndex = 3'(i);
    end
    regionCfg = regionCfgFlat[16*regionIndex +: 16];
  end
endmodule

// file: test/ebr_mem_model.sv
// Behavioural memory on the far side of the external bus.
// Assumes active-low commands; the bench picks the ready level and delay.
`timescale 1ns/1ns
module ebr_mem_model
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Bus pins from the controller.
  input wire logic readCmdN,
  input wire logic writeCmdN,
  input wire logic [23:0] addrOut,
  // Answers to the controller.
  output logic [15:0] adIn,
  output logic readyPin,
  // Bench control of the handshake.
  input wire logic readyPol,
  input wire logic [7:0] readyDelay
);
  logic cmdOn;
  logic [7:0] cmdCount_reg;
  assign cmdOn = !readCmdN || !writeCmdN;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmdCount_reg <= 8'h00;
      readyPin <= 1'b1;
    end
    else
    begin
      cmdCount_reg <= cmdOn ? cmdCount_reg + 8'h01 : 8'h00;
      // A slow device: ready stays inactive until the delay runs out.
      readyPin <= (cmdOn && cmdCount_reg >= readyDelay - 8'h01) ?
        readyPol : !readyPol;
    end
  end
  // Outside a read the lines toggle, so a stale value never matches.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      adIn <= 16'h0000;
    else
      adIn <= !readCmdN ? addrOut[15:0] ^ 16'h5A3C : ~adIn;
  end
endmodule

// file: test/tb_external_bus_region_timing.sv
// Self-checking bench for the region timing bus controller.
// Assumes the memory model answers reads and the ready handshake.
`timescale 1ns/1ns
module tb_external_bus_region_timing
  import ebr_pkg::*;
();
  localparam int READY_WAIT = 40;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [15:0] paddr, accWdata, accRdata, adOut, adIn, cfg, adLatch, adData;
  logic [2:0] clkKeep;
  logic [31:0] pwdata, prdata, seed, rnd32, rd;
  logic [7:0] configurationPort, port;
  logic longReset, accReq, accWrite, accDone, accRefused, strobe, cmdNow;
  logic [1:0] accByteEn, busTypeOut, selectLineCount;
  logic [23:0] accAddr, addrOut;
  logic [NUM_REGIONS-1:0] regionHit, chipSelectN, hit, csRest;
  logic latchStrobe, readCmdN, writeCmdN, upperByteEnableN, adOe;
  logic readyPin, readyPol;
  logic [3:0] segmentLines;
  logic [2:0] clockMultiplierSelect;
  int failures, checked, rg, lat, cmd, firstCmd, csLow, csOther, wrLow;
  int tot, k;

  ebr_top u_dut
  (
    .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .configurationPort, .longReset, .accReq, .accWrite,
    .accByteEn, .accAddr, .accWdata, .regionHit, .accDone, .accRefused,
    .accRdata, .latchStrobe, .readCmdN, .writeCmdN, .upperByteEnableN,
    .chipSelectN, .addrOut, .adOut, .adOe, .adIn, .readyPin, .busTypeOut,
    .segmentLines, .selectLineCount, .clockMultiplierSelect
  );
  ebr_mem_model u_mem
  (
    .clk, .resetn, .readCmdN, .writeCmdN, .addrOut, .adIn, .readyPin,
    .readyPol, .readyDelay(8'(READY_WAIT))
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // No window hit falls back to region zero.
  function automatic int region_of(input logic [NUM_REGIONS-1:0] h);
    int r;
    r = 0;
    for (int i = NUM_REGIONS - 1; i > 0; i--)
      if (h[i])
        r = i;
    return r;
  endfunction
  function automatic logic [3:0] seg_exp(input logic [1:0] f);
    return f == 2'h0 ? 4'h4 : f == 2'h1 ? 4'h0 : f == 2'h2 ? 4'h8 : 4'h2;
  endfunction
  function automatic int cmd_exp(input logic [15:0] c);
    return 2 + 2 * (15 - int'(c[F_WAIT_LSB +: 4]));
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    failures++;
    final_report();
  end

  task automatic apb(input logic wr, input logic [15:0] a,
    input logic [31:0] wd);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      failures++;
  endtask
  task automatic do_reset(input logic [7:0] p, input logic lng);
    resetn <= 1'b0;
    configurationPort <= p;
    longReset <= lng;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic check_straps(input logic [7:0] p, input logic lng);
    logic [31:0] exp;
    if (lng)
      clkKeep = p[7:5];
    exp = {24'h0, clkKeep, p[4:0]};
    apb(1'b0, ADDR_RESET_LATCH, 32'h0);
    check(rd, exp);
    check(clockMultiplierSelect, exp[7:5]);
    check(selectLineCount, p[2:1]);
    check(segmentLines, seg_exp(p[4:3]));
    apb(1'b0, ADDR_REGION_BASE, 32'h0);
    check(rd, {24'h0, p[7:6], 6'h00});
    apb(1'b1, ADDR_RESET_LATCH, ~exp);
    check(err, 1'b1);
    apb(1'b0, ADDR_RESET_LATCH, 32'h0);
    check(rd, exp);
    apb(1'b0, 16'hF0F0, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
  endtask
  // Runs one access and tallies what each bus pin did, cycle by cycle.
  task automatic run_access(input logic wr, input logic [1:0] be);
    int n;
    {lat, cmd, firstCmd, csLow, csOther, wrLow} = '0;
    adData = 16'h0000;
    rnd32 = rnd();
    rg = region_of(hit);
    @(posedge clk);
    {accReq, accWrite, accByteEn, regionHit} <= {1'b1, wr, be, hit};
    {accAddr, accWdata} <= {rnd32[23:0], rnd32[31:16]};
    @(posedge clk);
    accReq <= 1'b0;
    for (n = 1; n <= 200; n++)
    begin
      #1;
      cmdNow = wr ? (!writeCmdN || (strobe && !upperByteEnableN)) : !readCmdN;
      if (latchStrobe === 1'b1)
        adLatch = adOut;
      if (cmdNow === 1'b1 && adOe === 1'b1)
        adData = adOut;
      lat += int'(latchStrobe === 1'b1);
      cmd += int'(cmdNow === 1'b1);
      if (cmdNow === 1'b1 && firstCmd == 0)
        firstCmd = n;
      csLow += int'(chipSelectN[rg] === 1'b0);
      wrLow += int'(writeCmdN === 1'b0);
      csRest = chipSelectN;
      csRest[rg] = 1'b1;
      csOther += int'(csRest !== '1);
      if (accDone === 1'b1 || accRefused === 1'b1)
        break;
      @(posedge clk);
    end
    tot = n;
    if (n > 200)
      failures++;
  endtask

  initial
  begin
    seed = 32'h2D039429;
    {psel, penable, pwrite, paddr, pwdata, accReq, accWrite} = '0;
    {accByteEn, accAddr, accWdata, regionHit, readyPol, longReset} = '0;
    {hit, resetn, configurationPort} = '0;
    rnd32 = rnd();
    port = rnd32[7:0] & 8'hFE;
    strobe = 1'b1;
    do_reset(port, 1'b1);
    check_straps(port, 1'b1);
    for (k = 0; k < NUM_REGIONS; k++)
    begin
      rnd32 = rnd();
      apb(1'b1, ADDR_REGION_BASE + ADDR_REGION_STEP * 16'(k), rnd32);
      apb(1'b0, ADDR_REGION_BASE + ADDR_REGION_STEP * 16'(k), 32'h0);
      check(rd, {16'h0, rnd32[15:0] & REGION_WRITE_MASK});
    end
    // Every bus type, both gating modes and ready on and off at random.
    for (k = 0; k < 32; k++)
    begin
      rnd32 = rnd();
      hit = rnd32[4:0] & {NUM_REGIONS{rnd32[5]}};
      cfg = rnd32[31:16] & REGION_WRITE_MASK;
      cfg[F_TYPE_LSB +: 2] = k[1:0];
      cfg[F_ACTIVE] = (k % 8 != 7);
      readyPol <= cfg[F_RDY_POL];
      apb(1'b1, ADDR_REGION_BASE + ADDR_REGION_STEP * 16'(region_of(hit)),
        {16'h0, cfg});
      run_access(rnd32[6], 2'h3);
      if (!cfg[F_ACTIVE])
      begin
        check({accRefused, 31'(lat)}, {1'b1, 31'h0});
        continue;
      end
      check(lat, cfg[F_LATCH_LEN] ? 2 : 1);
      check(firstCmd - lat - 1, cfg[F_CMD_DELAY] ? 0 : 1);
      if (cfg[F_RDY_EN])
        check(cmd >= READY_WAIT && cmd <= READY_WAIT + 3, 1);
      else
        check(cmd, cmd_exp(cfg));
      check(tot, firstCmd + cmd + (cfg[F_TRISTATE] ? 0 : 2));
      check(csLow, cfg[accWrite ? F_WR_GATED : F_RD_GATED] ?
        cmd : firstCmd - 1 + cmd);
      check(csOther, 0);
      check(busTypeOut, cfg[F_TYPE_LSB +: 2]);
      check(addrOut, accAddr);
      if (accWrite)
        check(adData, cfg[F_TYPE_LSB + 1] ? accWdata
          : {8'h00, accWdata[7:0]});
      if (cfg[F_TYPE_LSB])
        check(adLatch, accAddr[15:0]);
      if (!accWrite)
        check(accRdata & {{8{cfg[F_TYPE_LSB + 1]}}, 8'hFF},
          (accAddr[15:0] ^ 16'h5A3C) & {{8{cfg[F_TYPE_LSB + 1]}}, 8'hFF});
    end
    // High byte only: the store strobe must stay idle in strobe mode.
    hit = 5'h02;
    apb(1'b1, ADDR_REGION_BASE + ADDR_REGION_STEP, 32'h0000_04BF);
    run_access(1'b1, 2'h2);
    check(wrLow, 0);
    check(cmd, 2);
    // A short reset keeps the clock selection taken at the last long reset.
    rnd32 = rnd();
    port = {~port[7:5], rnd32[4:0] | 5'h01};
    do_reset(port, 1'b0);
    check_straps(port, 1'b0);
    final_report();
  end
endmodule
